// ### hdl/twsc_params.svh
// Purpose: constants for the timer, watchdog and sleep control core
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes: offsets are byte addresses of 32-bit aligned words
`ifndef TWSC_PARAMS_SVH
`define TWSC_PARAMS_SVH
`define TWSC_OFS_CORE_CTRL 8'h00
`define TWSC_OFS_TIMER 8'h04
`define TWSC_OFS_SLEEP_WDT 8'h08
`define TWSC_OFS_IRQ_MASK 8'h0C
`define TWSC_OFS_IRQ_FLAG 8'h10
`define TWSC_OFS_INSTR 8'h14
`define TWSC_OFS_STATUS 8'h18
`define TWSC_OFS_EVENT 8'h1C
`define TWSC_CTRL_RW_MASK 8'h8F
`define TWSC_SLP_RW_MASK 8'h79
`define TWSC_MASK_RW_MASK 8'h0F
`define TWSC_BIT_TARGET 3
`define TWSC_BIT_GIE 6
`define TWSC_BIT_WATCHDOG_ENABLE 5
`define TWSC_BIT_SLEEP_CONTROL 4
`define TWSC_BIT_ODE 6
`define TWSC_BIT_WUD 0
`define TWSC_INS_WDT_CLR 0
`define TWSC_INS_SLEEP 1
`define TWSC_INS_INTERRUPT_DISABLE_INSTR 2
`define TWSC_INS_ENI 3
`define TWSC_INS_RETURN_FROM_INTERRUPT_INSTR 4
`define TWSC_RST_CTRL 8'h00
`define TWSC_RST_SLP 8'h11
`define TWSC_RST_MASK 8'h00
`define TWSC_CLK_NS 10
`define TWSC_WDT_PERIOD_US 18000
`define TWSC_OST_US 18000
`define TWSC_WDT_CYCLES ((`TWSC_WDT_PERIOD_US * 1000) / `TWSC_CLK_NS)
`define TWSC_OST_CYCLES ((`TWSC_OST_US * 1000 + `TWSC_CLK_NS - 1) / `TWSC_CLK_NS)
`define TWSC_RESP_OKAY 2'h0
`define TWSC_RESP_SLVERR 2'h2
`endif

// ### hdl/twsc_pkg.sv
// Purpose: types for the timer, watchdog and sleep control core
// Assumes: constants come from twsc_params.svh
// Notes: power state machine only
package twsc_pkg;
  typedef enum logic [1:0] {
    TWSC_RUN = 2'b00,
    TWSC_SLEEP = 2'b01,
    TWSC_OST = 2'b10
  } twsc_pwr_type;
endpackage : twsc_pkg

// ### hdl/twsc_core.sv
// Purpose: timer/counter, watchdog, shared prescaler, sleep and interrupt control
// Assumes: one 100 MHz clock; instruction events arrive as AXI writes to the instruction register
// Notes: mclk_in stands in for the instruction cycle and the watchdog oscillator
// Notes on behaviour
// [RULE_01] One 8-bit prescaler, one user at once
// [RULE_02] Target bit: 0 timer, 1 watchdog
// [RULE_03] Ratio code picks power-of-two divide
// [RULE_04] Timer write clears prescaler in timer mode
// [RULE_05] Watchdog clear or sleep clears both (code clears prescaler only when target is watchdog)
// [RULE_06] Timer steps once per instruction cycle
// [RULE_07] Watchdog runs in sleep, timeout resets
// [RULE_08] Watchdog base period about 18 ms
// [RULE_09] Enable bit needs build option set
// [RULE_10] Interrupt enable only by instructions
// [RULE_11] Control bits 4,5 read zero
// [RULE_12] Sleep bit: wake sets, fall sleeps
// [RULE_13] Start-up delay 18 ms on wake
// [RULE_14] Watchdog enabled after wake if option
// [RULE_15] Wake-up disable bit, read and write
// [RULE_16] Mask bits 0-3 enable four interrupts
// [RULE_17] Open-drain select bit drives pins
// [RULE_18] Flags set by events, read masked
// [RULE_19] Timeout bit set by instrs, cleared timeout
// [RULE_20] Timer wrap sets overflow flag
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "twsc_params.svh"
module twsc_core #(
  parameter int WDT_CYCLES = `TWSC_WDT_CYCLES,
  parameter int OST_CYCLES = `TWSC_OST_CYCLES,
  parameter bit WDT_BUILD_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins and events
  input wire logic wakeup_in,
  input wire logic [3:1] irq_event_in,
  // Status outputs
  output logic wdt_reset_out,
  output logic deep_sleep_out,
  output logic cpu_run_out,
  output logic open_drain_sel_out,
  output logic wakeup_disable_out,
  output logic pull_high_disable_out,
  output logic global_irq_en_out,
  output logic irq_pending_out
);

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wr_rdy;
    logic ar_rdy;
    logic o_dsleep;
    logic o_run;
    logic o_pend;
    logic [7:0] ctrl;
    logic [7:0] slp;
    logic [7:0] mask;
    logic [3:0] flags;
    logic [7:0] timer;
    logic [7:0] presc;
    logic [31:0] wdt_cnt;
    logic [31:0] ost_cnt;
    logic timeout_bit;
    logic wdt_rst;
    logic sleep_control_d;
    twsc_pkg::twsc_pwr_type pwr;
    logic [1:0] wk_sync;
    logic wk_d;
    logic [2:0] ev_s1;
    logic [2:0] ev_s2;
    logic [2:0] ev_d;
  } twsc_state_type;

  twsc_state_type st_r;
  twsc_state_type st_nxt;

  // Prescaler tap for ratio code and target
  function automatic logic presc_tick(input logic [7:0] cnt, input logic [2:0] code, input logic wdt_sel);
    logic [8:0] lim;
    lim = wdt_sel ? (9'h001 << code) : (9'h002 << code);
    presc_tick = ({1'b0, cnt} == (lim - 9'h001));
  endfunction : presc_tick

  logic wr_fire;
  logic rd_fire;
  logic wdt_on;
  logic run;
  logic timer_step;
  logic wdt_step;
  logic wdt_clr;
  logic sleep_ins;
  logic [7:0] wd8;
  logic [2:0] ev_rise;

  always_comb begin
    st_nxt = st_r;
    wd8 = st_r.w_data[7:0];
    run = (st_r.pwr == twsc_pkg::TWSC_RUN);
    wdt_clr = 1'b0;
    sleep_ins = 1'b0;
    timer_step = 1'b0;
    wdt_step = 1'b0;
    // Synchronise pins
    st_nxt.wk_sync = {st_r.wk_sync[0], wakeup_in};
    st_nxt.wk_d = st_r.wk_sync[1];
    st_nxt.ev_s1 = irq_event_in;
    st_nxt.ev_s2 = st_r.ev_s1;
    st_nxt.ev_d = st_r.ev_s2;
    ev_rise = st_r.ev_s2 & ~st_r.ev_d;
    // [RULE_09] Enable gated by option
    wdt_on = WDT_BUILD_OPTION && st_r.slp[`TWSC_BIT_WATCHDOG_ENABLE];
    // AXI write capture
    if (s_axi_awvalid_in && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata_in;
      st_nxt.w_strb = s_axi_wstrb_in;
    end
    wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (st_r.bvalid && s_axi_bready_in) begin
      st_nxt.bvalid = 1'b0;
    end
    // Prescaler and timer
    if (run && !st_r.ctrl[`TWSC_BIT_TARGET]) begin
      // [RULE_01] Prescaler serves timer
      if (presc_tick(st_r.presc, st_r.ctrl[2:0], 1'b0)) begin
        st_nxt.presc = 8'h00;
        timer_step = 1'b1;
      end else begin
        st_nxt.presc = st_r.presc + 8'h01;
      end
    end else if (!st_r.ctrl[`TWSC_BIT_TARGET]) begin
      st_nxt.presc = st_r.presc;
    end
    // [RULE_06] Timer increment
    if (run && st_r.ctrl[`TWSC_BIT_TARGET]) begin
      timer_step = 1'b1;
    end
    if (timer_step) begin
      st_nxt.timer = st_r.timer + 8'h01;
    end
    // [RULE_02] Prescaler serves watchdog
    if (st_r.ctrl[`TWSC_BIT_TARGET]) begin
      // [RULE_03] Ratio tap select
      if (presc_tick(st_r.presc, st_r.ctrl[2:0], 1'b1)) begin
        st_nxt.presc = 8'h00;
        wdt_step = 1'b1;
      end else begin
        st_nxt.presc = st_r.presc + 8'h01;
      end
    end else begin
      wdt_step = 1'b1;
    end
    // [RULE_07] Watchdog counts in sleep too
    st_nxt.wdt_rst = 1'b0;
    if (wdt_on && wdt_step) begin
      // [RULE_08] Base period count
      if (st_r.wdt_cnt >= 32'(WDT_CYCLES - 1)) begin
        st_nxt.wdt_cnt = 32'h00000000;
        st_nxt.wdt_rst = 1'b1;
      end else begin
        st_nxt.wdt_cnt = st_r.wdt_cnt + 32'h00000001;
      end
    end
    // Sleep state machine
    st_nxt.sleep_control_d = st_r.slp[`TWSC_BIT_SLEEP_CONTROL];
    case (st_r.pwr)
      twsc_pkg::TWSC_RUN: begin
        // [RULE_12] Falling sleep bit stops oscillator
        if (st_r.sleep_control_d && !st_r.slp[`TWSC_BIT_SLEEP_CONTROL]) begin
          st_nxt.pwr = twsc_pkg::TWSC_SLEEP;
        end
      end
      twsc_pkg::TWSC_SLEEP: begin
        if (!st_r.sleep_control_d && st_r.slp[`TWSC_BIT_SLEEP_CONTROL]) begin
          st_nxt.pwr = twsc_pkg::TWSC_OST;
          st_nxt.ost_cnt = 32'h00000000;
        end
      end
      twsc_pkg::TWSC_OST: begin
        // [RULE_13] Start-up delay count
        if (st_r.ost_cnt >= 32'(OST_CYCLES - 1)) begin
          st_nxt.pwr = twsc_pkg::TWSC_RUN;
          // [RULE_14] Watchdog on after wake
          if (WDT_BUILD_OPTION) begin
            st_nxt.slp[`TWSC_BIT_WATCHDOG_ENABLE] = 1'b1;
          end
        end else begin
          st_nxt.ost_cnt = st_r.ost_cnt + 32'h00000001;
        end
      end
      default: begin
        st_nxt.pwr = twsc_pkg::TWSC_RUN;
      end
    endcase
    // [RULE_20] Overflow flag on wrap
    if (timer_step && st_r.timer == 8'hFF) begin
      st_nxt.flags[0] = 1'b1;
    end
    // Register writes
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `TWSC_RESP_OKAY;
      if (st_r.w_strb[0]) begin
        case (st_r.aw_addr)
          `TWSC_OFS_CORE_CTRL: begin
            // [RULE_10] Interrupt enable kept on write
            // [RULE_11] Writable bits only
            st_nxt.ctrl = (wd8 & `TWSC_CTRL_RW_MASK) | (st_r.ctrl & ~`TWSC_CTRL_RW_MASK);
          end
          `TWSC_OFS_TIMER: begin
            st_nxt.timer = wd8;
            // [RULE_04] Timer write clears prescaler
            if (!st_r.ctrl[`TWSC_BIT_TARGET]) begin
              st_nxt.presc = 8'h00;
            end
          end
          `TWSC_OFS_SLEEP_WDT: begin
            // [RULE_15] Wake-up and open-drain bits
            st_nxt.slp = wd8 & `TWSC_SLP_RW_MASK;
          end
          `TWSC_OFS_IRQ_MASK: begin
            // [RULE_16] Mask bits
            st_nxt.mask = wd8 & `TWSC_MASK_RW_MASK;
          end
          `TWSC_OFS_IRQ_FLAG: begin
            st_nxt.flags = st_r.flags & wd8[3:0];
          end
          `TWSC_OFS_INSTR: begin
            wdt_clr = wd8[`TWSC_INS_WDT_CLR];
            sleep_ins = wd8[`TWSC_INS_SLEEP];
            if (wd8[`TWSC_INS_INTERRUPT_DISABLE_INSTR]) begin
              st_nxt.ctrl[`TWSC_BIT_GIE] = 1'b0;
            end
            if (wd8[`TWSC_INS_ENI] || wd8[`TWSC_INS_RETURN_FROM_INTERRUPT_INSTR]) begin
              st_nxt.ctrl[`TWSC_BIT_GIE] = 1'b1;
            end
          end
          `TWSC_OFS_STATUS, `TWSC_OFS_EVENT: begin
            st_nxt.bresp = `TWSC_RESP_OKAY;
          end
          default: begin
            st_nxt.bresp = `TWSC_RESP_SLVERR;
          end
        endcase
      end
    end
    // [RULE_05] Clear watchdog, and prescaler when the target is watchdog
    if (wdt_clr || sleep_ins) begin
      st_nxt.wdt_cnt = 32'h00000000;
      if (st_r.ctrl[`TWSC_BIT_TARGET]) begin
        st_nxt.presc = 8'h00;
      end
      // [RULE_19] Timeout bit set by instrs
      st_nxt.timeout_bit = 1'b1;
    end
    if (sleep_ins) begin
      st_nxt.slp[`TWSC_BIT_SLEEP_CONTROL] = 1'b0;
    end
    // [RULE_12] Wake falling edge sets bit
    if (st_r.wk_d && !st_r.wk_sync[1] && !st_r.slp[`TWSC_BIT_WUD]) begin
      st_nxt.slp[`TWSC_BIT_SLEEP_CONTROL] = 1'b1;
    end
    // [RULE_18] Event set wins over clear
    st_nxt.flags[3:1] = st_nxt.flags[3:1] | ev_rise;
    if (timer_step && st_r.timer == 8'hFF) begin
      st_nxt.flags[0] = 1'b1;
    end
    // [RULE_19] Timeout clears bit
    if (st_nxt.wdt_rst) begin
      st_nxt.timeout_bit = 1'b0;
    end
    // AXI read
    // Address taken in the cycle the ready pulse is high
    rd_fire = s_axi_arvalid_in && st_r.ar_rdy;
    st_nxt.ar_rdy = s_axi_arvalid_in && !st_r.ar_rdy && !st_r.rvalid;
    if (st_r.rvalid && s_axi_rready_in) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `TWSC_RESP_OKAY;
      st_nxt.rdata = 32'h00000000;
      case (s_axi_araddr_in)
        `TWSC_OFS_CORE_CTRL: st_nxt.rdata[7:0] = st_r.ctrl & 8'hCF;
        `TWSC_OFS_TIMER: st_nxt.rdata[7:0] = st_r.timer;
        `TWSC_OFS_SLEEP_WDT: st_nxt.rdata[7:0] = st_r.slp;
        `TWSC_OFS_IRQ_MASK: st_nxt.rdata[7:0] = st_r.mask;
        // [RULE_18] Masked flag read
        `TWSC_OFS_IRQ_FLAG: st_nxt.rdata[7:0] = {4'h0, st_r.flags & st_r.mask[3:0]};
        `TWSC_OFS_INSTR: st_nxt.rdata = 32'h00000000;
        `TWSC_OFS_STATUS: st_nxt.rdata[7:0] = {3'h0, st_r.timeout_bit, 2'h0, st_r.pwr};
        `TWSC_OFS_EVENT: st_nxt.rdata[7:0] = st_r.presc;
        default: st_nxt.rresp = `TWSC_RESP_SLVERR;
      endcase
    end
    // Registered copies of derived outputs
    // Write ready pulse while both halves held
    st_nxt.wr_rdy = st_nxt.aw_got && st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.o_dsleep = (st_nxt.pwr == twsc_pkg::TWSC_SLEEP);
    st_nxt.o_run = (st_nxt.pwr == twsc_pkg::TWSC_RUN);
    st_nxt.o_pend = |(st_nxt.flags & st_nxt.mask[3:0]);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
      st_r.ctrl <= `TWSC_RST_CTRL;
      st_r.slp <= `TWSC_RST_SLP;
      st_r.mask <= `TWSC_RST_MASK;
      st_r.timeout_bit <= 1'b1;
      st_r.sleep_control_d <= 1'b1;
      st_r.o_run <= 1'b1;
      st_r.pwr <= twsc_pkg::TWSC_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign s_axi_awready_out = st_r.wr_rdy;
  assign s_axi_wready_out = st_r.wr_rdy;
  assign s_axi_bvalid_out = st_r.bvalid;
  assign s_axi_bresp_out = st_r.bresp;
  assign s_axi_arready_out = st_r.ar_rdy;
  assign s_axi_rvalid_out = st_r.rvalid;
  assign s_axi_rdata_out = st_r.rdata;
  assign s_axi_rresp_out = st_r.rresp;
  // [RULE_07] Watchdog reset pulse
  assign wdt_reset_out = st_r.wdt_rst;
  assign deep_sleep_out = st_r.o_dsleep;
  assign cpu_run_out = st_r.o_run;
  // [RULE_17] Open-drain select out
  assign open_drain_sel_out = st_r.slp[`TWSC_BIT_ODE];
  assign wakeup_disable_out = st_r.slp[`TWSC_BIT_WUD];
  assign pull_high_disable_out = st_r.ctrl[7];
  assign global_irq_en_out = st_r.ctrl[`TWSC_BIT_GIE];
  assign irq_pending_out = st_r.o_pend;

endmodule : twsc_core

// ### bench/twsc_sva.sv
// Purpose: port checks for twsc_core
// Assumes: OST_CYCLES between 10 and 50
// Notes: attached by the bind at the foot
`timescale 1ns/10ps
module twsc_sva (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Bus
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Power and watchdog
  input wire logic wakeup_in,
  input wire logic wdt_reset_out,
  input wire logic deep_sleep_out,
  input wire logic cpu_run_out,
  input wire logic wakeup_disable_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_aw_pair;
    s_axi_awready_out == s_axi_wready_out;
  endproperty
  a_aw_pair: assert property (p_aw_pair) else $error("ready pair split");
  property p_aw_resp;
    s_axi_awready_out |=> s_axi_bvalid_out;
  endproperty
  a_aw_resp: assert property (p_aw_resp) else $error("no write response");
  property p_bv_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_bv_hold: assert property (p_bv_hold) else $error("write response dropped");
  property p_rv_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_rv_hold: assert property (p_rv_hold) else $error("read data dropped");
  property p_wdt_pulse;
    wdt_reset_out |=> !wdt_reset_out;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("reset pulse too long");
  property p_sleep_halt;
    deep_sleep_out |-> !cpu_run_out;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("runs in sleep");
  property p_wake_ost;
    $fell(wakeup_in) && deep_sleep_out |=> !cpu_run_out [*8];
  endproperty
  a_wake_ost: assert property (p_wake_ost) else $error("start-up delay short");
  property p_wake_end;
    $fell(wakeup_in) && deep_sleep_out && !wakeup_disable_out |-> ##[10:60] cpu_run_out;
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("no wake");
  c_wdt: cover property (wdt_reset_out);
  c_wake: cover property ($fell(wakeup_in) && deep_sleep_out && !wakeup_disable_out);
  c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule : twsc_sva
bind twsc_core twsc_sva i_sva (.mclk_in, .rst_n_in, .s_axi_awready_out, .s_axi_wready_out,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_rdata_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .wakeup_in, .wdt_reset_out, .deep_sleep_out, .cpu_run_out, .wakeup_disable_out);

// ### bench/timer_watchdog_sleep_ctrl_tb.sv
// Purpose: self-checking bench for twsc_core
// Assumes: watchdog 50 and start-up 20 cycles
// Notes: registers reached over AXI4-Lite
`timescale 1ns/10ps
module timer_watchdog_sleep_ctrl_tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic wake = 1'b1;
  logic [3:1] ev = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic wdt_rst, dsleep, run, open_drain_sel, wud, phd, gie, pend;
  wire [2:0] obs = {pend, run, wdt_rst};
  int mismatches = 0;
  int n_checks = 0;

  twsc_core #(.WDT_CYCLES(50), .OST_CYCLES(20), .WDT_BUILD_OPTION(1'b1)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .wakeup_in(wake), .irq_event_in(ev), .wdt_reset_out(wdt_rst), .deep_sleep_out(dsleep),
    .cpu_run_out(run), .open_drain_sel_out(open_drain_sel), .wakeup_disable_out(wud),
    .pull_high_disable_out(phd), .global_irq_en_out(gie), .irq_pending_out(pend));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge mclk_in); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge mclk_in); while (bvalid !== 1'b1);
    chk(bresp, 2'h0);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    @(posedge mclk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk_in); while (rvalid !== 1'b1);
    chk(rdata, exp);
    chk(rresp, er);
    rready <= 1'b0;
  endtask : rd

  task automatic wait_for(input int idx, input logic v, input int lo, input int hi);
    int n;
    for (n = 0; n < hi && obs[idx] !== v; n++) @(posedge mclk_in);
    chk(n >= lo && (n < hi || lo == hi), 32'h1);
  endtask : wait_for

  task automatic do_reset;
    rst_n_in <= 1'b0;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
  endtask : do_reset

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic t_regs;
    rd(8'h00, 32'h00);
    rd(8'h08, 32'h11);
    rd(8'h0C, 32'h00);
    rd(8'h18, 32'h10);
    chk({wud, run, gie, dsleep}, 4'b1100);
    wr(8'h00, 8'hFF);
    rd(8'h00, 32'h8F);
    chk({phd, gie}, 2'b10);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 32'h0F);
    wr(8'h08, 8'h51);
    rd(8'h08, 32'h51);
    chk({open_drain_sel, wud}, 2'b11);
    wr(8'h08, 8'h10);
    chk({open_drain_sel, wud}, 2'b00);
    rd(8'h20, 32'h0, 2'h2);
    $display("test regs done");
  endtask : t_regs

  task automatic t_gie;
    wr(8'h14, 8'h08);
    chk(gie, 1'b1);
    wr(8'h00, 8'h00);
    chk(gie, 1'b1);
    wr(8'h14, 8'h04);
    chk(gie, 1'b0);
    wr(8'h00, 8'h40);
    chk(gie, 1'b0);
    wr(8'h14, 8'h10);
    rd(8'h00, 32'h40);
    $display("test gie done");
  endtask : t_gie

  task automatic t_timer;
    int p;
    wr(8'h0C, 8'h01);
    for (int k = -1; k < 8; k++) begin
      p = (k < 0) ? 1 : (2 << k);
      wr(8'h00, (k < 0) ? 8'h08 : 8'(k));
      wr(8'h04, 8'h00);
      wr(8'h10, 8'h00);
      wr(8'h04, 8'hFF);
      wait_for(2, 1'b1, p - 6, p + 8);
    end
    rd(8'h10, 32'h01);
    wr(8'h10, 8'h00);
    wr(8'h0C, 8'h0F);
    @(posedge mclk_in);
    ev <= 3'b111;
    repeat (4) @(posedge mclk_in);
    ev <= 3'b000;
    rd(8'h10, 32'h0E);
    wr(8'h10, 8'h0B);
    rd(8'h10, 32'h0A);
    wr(8'h0C, 8'h04);
    rd(8'h10, 32'h00);
    chk(pend, 1'b0);
    $display("test timer done");
  endtask : t_timer

  task automatic t_sleep_wdt;
    wr(8'h08, 8'h30);
    wr(8'h14, 8'h02);
    @(posedge mclk_in);
    chk({dsleep, run}, 2'b10);
    rd(8'h18, 32'h11);
    wait_for(0, 1'b1, 35, 60);
    $display("test sleep watchdog done");
  endtask : t_sleep_wdt

  task automatic t_pin_wake;
    wr(8'h08, 8'h01);
    @(posedge mclk_in);
    chk({dsleep, run}, 2'b10);
    @(posedge mclk_in);
    wake <= 1'b0;
    wait_for(1, 1'b1, 40, 40);
    wake <= 1'b1;
    wr(8'h08, 8'h00);
    wake <= 1'b0;
    wait_for(1, 1'b1, 18, 40);
    wait_for(0, 1'b1, 0, 80);
    wake <= 1'b1;
    $display("test pin wake done");
  endtask : t_pin_wake

  task automatic t_wdt;
    wr(8'h00, 8'h09);
    wr(8'h08, 8'h31);
    repeat (4) begin
      wr(8'h14, 8'h01);
      wait_for(0, 1'b1, 60, 60);
    end
    wait_for(0, 1'b1, 25, 50);
    rd(8'h18, 32'h00);
    wr(8'h14, 8'h01);
    rd(8'h18, 32'h10);
    $display("test watchdog done");
  endtask : t_wdt

  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end

  initial begin
    do_reset;
    t_regs;
    t_gie;
    t_timer;
    do_reset;
    t_sleep_wdt;
    do_reset;
    t_pin_wake;
    do_reset;
    t_wdt;
    tally_and_finish;
  end
endmodule : timer_watchdog_sleep_ctrl_tb
